//--- exec_consts.svh
// constants for the subtract, swap, xor, direction-load and sleep execution block
`ifndef EXEC_CONSTS_SVH
`define EXEC_CONSTS_SVH

// ****************************************
// register byte addresses
// ****************************************
`define ADDR_ACC        8'h00
`define ADDR_FILE_VAL   8'h04
`define ADDR_INSTR      8'h08
`define ADDR_STATUS     8'h0c
`define ADDR_FILE_RES   8'h10
`define ADDR_DIR        8'h14
`define ADDR_WDOG       8'h18
`define ADDR_WAKE       8'h1c

// ****************************************
// field positions
// ****************************************
`define INS_OP_LSB      0
`define INS_DEST_BIT    3
`define INS_OPND_LSB    8
`define STS_CARRY       0
`define STS_HALF        1
`define STS_ZERO        2
`define STS_PDOWN       3
`define STS_EXPIRY      4
`define WAKE_BIT        0

// ****************************************
// operation codes
// ****************************************
`define OP_LIT_SUB      3'h0
`define OP_REG_SUB      3'h1
`define OP_REG_SUBB     3'h2
`define OP_NIB_SWAP     3'h3
`define OP_LIT_XOR      3'h4
`define OP_REG_XOR      3'h5
`define OP_DIR_LOAD     3'h6
`define OP_SLEEP        3'h7

// ****************************************
// direction-load operands and reset values
// ****************************************
`define DIR_SEL_A       8'h05
`define DIR_SEL_B       8'h06
`define DIR_SEL_C       8'h07
`define DIR_RESET       8'hff
`define STATUS_RESET    5'h18
`define PRESCALE_W      8

`endif

//--- exec_pkg.sv
// types shared by the execution block and its leaves
package exec_pkg;

  typedef logic [2:0] op_code_t;

  typedef struct packed {
    logic [7:0] operand;
    logic       dest;
    op_code_t   op;
  } instr_t;

  typedef struct packed {
    logic [7:0] result;
    logic       carry;
    logic       half;
    logic       zero;
    logic       upd_carry;
    logic       upd_zero;
    logic       to_acc;
    logic       to_file;
  } alu_out_t;

  typedef enum logic {
    CORE_RUN,
    CORE_ASLEEP
  } core_state_t;

endpackage

//--- exec_alu.sv
// combinational datapath for subtract, swap and exclusive-or operations
`timescale 1ns/1ps
`include "exec_consts.svh"

module exec_alu (
  input  wire logic              [2:0] op,
  input  wire logic                    dest,
  input  wire logic              [7:0] acc,
  input  wire logic              [7:0] fval,
  input  wire logic              [7:0] lit,
  input  wire logic                    carry_in,
  output exec_pkg::alu_out_t           res
);

  logic       is_lit_sub;
  logic       is_sub;
  logic [7:0] minuend;
  logic       cin;
  logic [8:0] diff;
  logic [4:0] diff_lo;
  logic [7:0] swapped;
  logic [7:0] xored;
  logic [7:0] xor_src;

  assign is_lit_sub = (op == `OP_LIT_SUB);
  assign is_sub     = is_lit_sub | (op == `OP_REG_SUB) | (op == `OP_REG_SUBB);
  assign minuend    = is_lit_sub ? lit : fval;
  // two's complement: a + ~w + 1, borrow variant uses carry as not-borrow
  assign cin        = (op == `OP_REG_SUBB) ? carry_in : 1'b1;
  assign diff       = {1'b0, minuend} + {1'b0, ~acc} + {8'h00, cin};
  assign diff_lo    = {1'b0, minuend[3:0]} + {1'b0, ~acc[3:0]} + {4'h0, cin};
  assign swapped    = {fval[3:0], fval[7:4]};
  assign xor_src    = (op == `OP_LIT_XOR) ? lit : fval;
  assign xored      = acc ^ xor_src;

  always_comb begin
    res           = '0;
    res.carry     = diff[8];
    res.half      = diff_lo[4];
    res.upd_carry = is_sub;
    res.upd_zero  = is_sub | (op == `OP_LIT_XOR) | (op == `OP_REG_XOR);
    unique case (op)
      `OP_LIT_SUB: begin
        res.result = diff[7:0];
        res.to_acc = 1'b1;
      end
      `OP_REG_SUB, `OP_REG_SUBB: begin
        res.result  = diff[7:0];
        res.to_acc  = ~dest;
        res.to_file = dest;
      end
      `OP_NIB_SWAP: begin
        res.result  = swapped;
        res.to_acc  = ~dest;
        res.to_file = dest;
      end
      `OP_LIT_XOR: begin
        res.result = xored;
        res.to_acc = 1'b1;
      end
      `OP_REG_XOR: begin
        res.result  = xored;
        res.to_acc  = ~dest;
        res.to_file = dest;
      end
      default: begin
        res.result = acc;
      end
    endcase
    res.zero = (res.result == 8'h00);
  end

endmodule

//--- exec_wdog.sv
// watchdog prescaler and counter with synchronous clear
`timescale 1ns/1ps
`include "exec_consts.svh"

module exec_wdog #(
  parameter int PRESCALE_W = `PRESCALE_W
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  run,
  input  wire logic                  clear,
  output logic      [7:0]            count,
  output logic      [PRESCALE_W-1:0] prescale
);

  logic [7:0]            count_ff;
  logic [PRESCALE_W-1:0] pre_ff;
  logic                  pre_wrap;

  assign pre_wrap = &pre_ff;
  assign count    = count_ff;
  assign prescale = pre_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_ff <= 8'h00;
      pre_ff   <= '0;
    end else if (clear) begin
      count_ff <= 8'h00;
      pre_ff   <= '0;
    end else if (run) begin
      pre_ff <= pre_ff + PRESCALE_W'(1);
      if (pre_wrap) begin
        count_ff <= count_ff + 8'h01;
      end
    end
  end

endmodule

//--- exec_core.sv
// apb-reached execution unit: subtract, swap, xor, direction load and sleep entry
//
// Overview of operation
// - literal minus accumulator into accumulator; carry when acc <= literal, same per nibble.
// - sleep clears powerdown_flag and sets expiry_flag.
// - sleep zeroes watchdog_counter and its prescaler.
// - on the same clock edge as those updates, sleep halts execution and stops the oscillator.
// - register minus accumulator; carry when acc <= register, nibble half-carry, zero.
// - destination bit zero writes accumulator, one writes back the file register.
// - with borrow: register minus accumulator minus inverted carry; update C, DC, Z.
// - nibble swap exchanges register halves into destination; flags untouched.
// - literal xor accumulator into accumulator; only zero flag changes.
// - register xor accumulator into destination; only zero flag changes.
// - direction load copies accumulator to port A, B or C for operand 5, 6, 7.
//
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "exec_consts.svh"

module exec_core #(
  parameter int PRESCALE_W = `PRESCALE_W
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             file_we,
  output logic      [6:0]  file_addr,
  output logic      [7:0]  file_wdata,
  output logic      [7:0]  port_a_direction,
  output logic      [7:0]  port_b_direction,
  output logic      [7:0]  port_c_direction,
  output logic             halted,
  output logic             osc_run
);

  // ****************************************
  // state
  // ****************************************
  logic [31:0]               rdata_ff;
  logic                      pready_ff;
  logic                      pslverr_ff;
  logic [7:0]                acc_ff;
  logic [7:0]                fval_ff;
  exec_pkg::instr_t          instr_ff;
  logic [4:0]                status_ff;
  logic                      file_we_ff;
  logic [6:0]                file_addr_ff;
  logic [7:0]                file_wdata_ff;
  logic [7:0]                dir_a_ff;
  logic [7:0]                dir_b_ff;
  logic [7:0]                dir_c_ff;
  exec_pkg::core_state_t     state_ff;
  logic                      osc_run_ff;
  logic                      halted_ff;

  logic [7:0]                nxt_acc;
  logic [7:0]                nxt_fval;
  logic [4:0]                nxt_status;
  exec_pkg::core_state_t     nxt_state;

  // ****************************************
  // apb decode
  // ****************************************
  logic                      access;
  logic                      done;
  logic                      first;
  logic                      hit_acc;
  logic                      hit_fval;
  logic                      hit_instr;
  logic                      hit_status;
  logic                      hit_fres;
  logic                      hit_dir;
  logic                      hit_wdog;
  logic                      hit_wake;
  logic                      mapped;
  logic                      wr_acc;
  logic                      wr_fval;
  logic                      wr_instr;
  logic                      wr_status;
  logic                      wr_wake;
  logic [31:0]               rd_mux;

  assign access     = psel & penable;
  assign first      = access & ~pready_ff;
  assign done       = access & pready_ff;
  assign hit_acc    = (paddr == `ADDR_ACC);
  assign hit_fval   = (paddr == `ADDR_FILE_VAL);
  assign hit_instr  = (paddr == `ADDR_INSTR);
  assign hit_status = (paddr == `ADDR_STATUS);
  assign hit_fres   = (paddr == `ADDR_FILE_RES);
  assign hit_dir    = (paddr == `ADDR_DIR);
  assign hit_wdog   = (paddr == `ADDR_WDOG);
  assign hit_wake   = (paddr == `ADDR_WAKE);
  assign mapped     = hit_acc | hit_fval | hit_instr | hit_status | hit_fres
                    | hit_dir | hit_wdog | hit_wake;
  assign wr_acc     = done & pwrite & hit_acc;
  assign wr_fval    = done & pwrite & hit_fval;
  assign wr_instr   = done & pwrite & hit_instr;
  assign wr_status  = done & pwrite & hit_status;
  assign wr_wake    = done & pwrite & hit_wake & pwdata[`WAKE_BIT];

  // ****************************************
  // instruction issue
  // ****************************************
  exec_pkg::instr_t          ins_new;
  exec_pkg::alu_out_t        alu_res;
  logic                      running;
  logic                      exec;
  logic                      exec_sleep;
  logic                      exec_dir;
  logic                      acc_load;
  logic                      file_load;
  logic [7:0]                wd_count;
  logic [PRESCALE_W-1:0]     wd_pre;

  // op in [2:0], destination in [3], operand in [15:8]
  assign ins_new    = {pwdata[15:8], pwdata[3], pwdata[2:0]};
  assign running    = (state_ff == exec_pkg::CORE_RUN);
  // issue is refused while asleep
  assign exec       = wr_instr & running;
  assign exec_sleep = exec & (ins_new.op == `OP_SLEEP);
  assign exec_dir   = exec & (ins_new.op == `OP_DIR_LOAD);
  assign acc_load   = exec & alu_res.to_acc;
  assign file_load  = exec & alu_res.to_file;

  exec_alu u_alu (
    .op       (ins_new.op),
    .dest     (ins_new.dest),
    .acc      (acc_ff),
    .fval     (fval_ff),
    .lit      (ins_new.operand),
    .carry_in (status_ff[`STS_CARRY]),
    .res      (alu_res)
  );

  exec_wdog #(
    .PRESCALE_W (PRESCALE_W)
  ) u_wdog (
    .pclk     (pclk),
    .presetn  (presetn),
    .run      (running),
    .clear    (exec_sleep),
    .count    (wd_count),
    .prescale (wd_pre)
  );

  // ****************************************
  // next values
  // ****************************************
  assign nxt_acc  = wr_acc ? pwdata[7:0] : (acc_load ? alu_res.result : acc_ff);
  assign nxt_fval = wr_fval ? pwdata[7:0] : (file_load ? alu_res.result : fval_ff);

  always_comb begin
    nxt_status = status_ff;
    if (wr_status) begin
      nxt_status = pwdata[4:0];
    end else if (exec_sleep) begin
      nxt_status[`STS_PDOWN]  = 1'b0;
      nxt_status[`STS_EXPIRY] = 1'b1;
    end else if (exec) begin
      if (alu_res.upd_carry) begin
        nxt_status[`STS_CARRY] = alu_res.carry;
        nxt_status[`STS_HALF]  = alu_res.half;
      end
      if (alu_res.upd_zero) begin
        nxt_status[`STS_ZERO] = alu_res.zero;
      end
    end
  end

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      exec_pkg::CORE_RUN: begin
        if (exec_sleep) begin
          nxt_state = exec_pkg::CORE_ASLEEP;
        end
      end
      exec_pkg::CORE_ASLEEP: begin
        if (wr_wake) begin
          nxt_state = exec_pkg::CORE_RUN;
        end
      end
    endcase
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (1'b1)
      hit_acc:    rd_mux[7:0]  = acc_ff;
      hit_fval:   rd_mux[7:0]  = fval_ff;
      hit_instr:  rd_mux[15:0] = {instr_ff.operand, 4'h0, instr_ff.dest, instr_ff.op};
      hit_status: rd_mux[4:0]  = status_ff;
      hit_fres:   rd_mux[14:0] = {file_addr_ff, file_wdata_ff};
      hit_dir:    rd_mux[23:0] = {dir_c_ff, dir_b_ff, dir_a_ff};
      hit_wdog: begin
        rd_mux[7:0]  = wd_count;
        rd_mux[15:8] = 8'(wd_pre);
        rd_mux[16]   = ~running;
      end
      default:    rd_mux       = 32'h0000_0000;
    endcase
  end

  // ****************************************
  // bus registers: one wait state per access
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
    end else begin
      pready_ff  <= first;
      pslverr_ff <= first & ~mapped;
      rdata_ff   <= (first & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // ****************************************
  // architectural registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_ff    <= 8'h00;
      fval_ff   <= 8'h00;
      instr_ff  <= '0;
      status_ff <= `STATUS_RESET;
      state_ff  <= exec_pkg::CORE_RUN;
    end else begin
      acc_ff    <= nxt_acc;
      fval_ff   <= nxt_fval;
      status_ff <= nxt_status;
      state_ff  <= nxt_state;
      if (exec) begin
        instr_ff <= ins_new;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      file_we_ff    <= 1'b0;
      file_addr_ff  <= 7'h00;
      file_wdata_ff <= 8'h00;
    end else begin
      file_we_ff <= file_load;
      if (file_load) begin
        file_addr_ff  <= ins_new.operand[6:0];
        file_wdata_ff <= alu_res.result;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_a_ff <= `DIR_RESET;
      dir_b_ff <= `DIR_RESET;
      dir_c_ff <= `DIR_RESET;
    end else if (exec_dir) begin
      if (ins_new.operand == `DIR_SEL_A) dir_a_ff <= acc_ff;
      if (ins_new.operand == `DIR_SEL_B) dir_b_ff <= acc_ff;
      if (ins_new.operand == `DIR_SEL_C) dir_c_ff <= acc_ff;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_run_ff <= 1'b1;
      halted_ff  <= 1'b0;
    end else begin
      osc_run_ff <= (nxt_state == exec_pkg::CORE_RUN);
      halted_ff  <= (nxt_state == exec_pkg::CORE_ASLEEP);
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign prdata           = rdata_ff;
  assign pready           = pready_ff;
  assign pslverr          = pslverr_ff;
  assign file_we          = file_we_ff;
  assign file_addr        = file_addr_ff;
  assign file_wdata       = file_wdata_ff;
  assign port_a_direction = dir_a_ff;
  assign port_b_direction = dir_b_ff;
  assign port_c_direction = dir_c_ff;
  assign halted           = halted_ff;
  assign osc_run          = osc_run_ff;

endmodule

//--- exec_core_assertions.sv
// concurrent checks on the ports of the execution block
`timescale 1ns/1ps
`include "exec_consts.svh"

module exec_core_assertions #(
  parameter int PRESCALE_W = 8
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        file_we,
  input wire logic [6:0]  file_addr,
  input wire logic [7:0]  file_wdata,
  input wire logic [7:0]  port_a_direction,
  input wire logic [7:0]  port_b_direction,
  input wire logic [7:0]  port_c_direction,
  input wire logic        halted,
  input wire logic        osc_run
);
  // ****************************************
  // helper state and properties
  // ****************************************
  logic [6:0] opnd_ff;

  // operand of the last accepted instruction write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opnd_ff <= 7'h00;
    end else if (pready && pwrite && paddr == `ADDR_INSTR) begin
      opnd_ff <= pwdata[14:8];
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_setup_access;
    (psel && !penable) ##1 (psel && penable);
  endsequence
  sequence s_instr_done;
    pready && psel && pwrite && paddr == `ADDR_INSTR && !halted;
  endsequence

  property p_one_wait;
    s_setup_access |-> !pready ##1 pready;
  endproperty
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  property p_err_ready;
    pslverr |-> pready && psel && penable;
  endproperty
  property p_rdata_idle;
    !pready |-> prdata == 32'h0;
  endproperty
  property p_halt_inv;
    halted != osc_run;
  endproperty
  property p_we_pulse;
    file_we |=> !file_we;
  endproperty
  property p_dir_hold;
    $changed({port_a_direction, port_b_direction, port_c_direction})
      |-> $past(pready && pwrite && paddr == `ADDR_INSTR);
  endproperty
  property p_sleep_stop;
    s_instr_done ##0 (pwdata[2:0] == `OP_SLEEP) |-> ##[1:2] (!osc_run && halted);
  endproperty
  property p_wb;
    s_instr_done ##0 (pwdata[3] && pwdata[2:0] inside
      {`OP_REG_SUB, `OP_REG_SUBB, `OP_NIB_SWAP, `OP_REG_XOR})
      |-> ##[1:2] (file_we && file_addr == opnd_ff);
  endproperty

  a_one_wait: assert property (p_one_wait) else $error("ready not in second access cycle");
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
  a_err_ready: assert property (p_err_ready) else $error("error outside access completion");
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero when idle");
  a_halt_inv: assert property (p_halt_inv) else $error("halted equals oscillator run");
  a_we_pulse: assert property (p_we_pulse) else $error("write-back pulse too long");
  a_dir_hold: assert property (p_dir_hold) else $error("direction moved");
  a_sleep_stop: assert property (p_sleep_stop) else $error("sleep did not halt");
  a_wb: assert property (p_wb) else $error("no write-back to file address");
endmodule

bind exec_core exec_core_assertions #(.PRESCALE_W(PRESCALE_W)) i_exec_core_assertions (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .file_we(file_we), .file_addr(file_addr), .file_wdata(file_wdata),
  .port_a_direction(port_a_direction), .port_b_direction(port_b_direction),
  .port_c_direction(port_c_direction), .halted(halted), .osc_run(osc_run));

//--- exec_file_model.sv
// far-side file register model that records write-backs
`timescale 1ns/1ps

module exec_file_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       file_we,
  input  wire logic [6:0] file_addr,
  input  wire logic [7:0] file_wdata,
  output logic      [7:0] wb_count_ff,
  output logic      [6:0] wb_addr_ff,
  output logic      [7:0] wb_data_ff
);
  // ****************************************
  // write-back capture
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wb_count_ff <= 8'h00;
      wb_addr_ff  <= 7'h00;
      wb_data_ff  <= 8'h00;
    end else if (file_we) begin
      wb_count_ff <= wb_count_ff + 8'h01;
      wb_addr_ff  <= file_addr;
      wb_data_ff  <= file_wdata;
    end
  end
endmodule

//--- tb.sv
// self-checking bench for the execution block
`timescale 1ns/1ps
`include "exec_consts.svh"

module tb;
  // ****************************************
  // signals, table and tasks
  // ****************************************
  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] fval;
    logic [7:0] sts;
    logic [2:0] op;
    logic       dest;
    logic [7:0] opnd;
    logic [7:0] e_acc;
    logic [7:0] e_fval;
    logic [7:0] e_sts;
  } row_t;

  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        file_we;
  logic [6:0]  file_addr;
  logic [7:0]  file_wdata;
  logic [7:0]  port_a_direction;
  logic [7:0]  port_b_direction;
  logic [7:0]  port_c_direction;
  logic        halted;
  logic        osc_run;
  logic [7:0]  wb_count_ff;
  logic [6:0]  wb_addr_ff;
  logic [7:0]  wb_data_ff;
  logic [31:0] rd;
  logic        er;
  logic [7:0]  wb0;
  logic [23:0] dir_exp;
  row_t        r;
  int          mismatches = 0;
  int          compares = 0;
  row_t        rows [11] = '{
    '{8'h05, 8'h33, 8'h18, `OP_LIT_SUB, 1'b0, 8'h05, 8'h00, 8'h33, 8'h1f},
    '{8'h10, 8'h33, 8'h18, `OP_LIT_SUB, 1'b0, 8'h0f, 8'hff, 8'h33, 8'h1a},
    '{8'h01, 8'h00, 8'h18, `OP_REG_SUB, 1'b1, 8'h20, 8'h01, 8'hff, 8'h18},
    '{8'h22, 8'h53, 8'h18, `OP_REG_SUB, 1'b0, 8'h21, 8'h31, 8'h53, 8'h1b},
    '{8'h0f, 8'h10, 8'h18, `OP_REG_SUBB, 1'b0, 8'h22, 8'h00, 8'h10, 8'h1d},
    '{8'h01, 8'h00, 8'h19, `OP_REG_SUBB, 1'b1, 8'h7f, 8'h01, 8'hff, 8'h18},
    '{8'h11, 8'ha5, 8'h1f, `OP_NIB_SWAP, 1'b1, 8'h03, 8'h11, 8'h5a, 8'h1f},
    '{8'h11, 8'h3c, 8'h18, `OP_NIB_SWAP, 1'b0, 8'h04, 8'hc3, 8'h3c, 8'h18},
    '{8'h5a, 8'h33, 8'h1b, `OP_LIT_XOR, 1'b0, 8'h5a, 8'h00, 8'h33, 8'h1f},
    '{8'hf0, 8'h0f, 8'h1c, `OP_REG_XOR, 1'b1, 8'h40, 8'hf0, 8'hff, 8'h18},
    '{8'h81, 8'h81, 8'h19, `OP_REG_XOR, 1'b0, 8'h41, 8'h00, 8'h81, 8'h1d}};

  always #12.5 pclk = ~pclk;

  exec_core #(.PRESCALE_W(2)) i_exec_core (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .file_we(file_we), .file_addr(file_addr), .file_wdata(file_wdata),
    .port_a_direction(port_a_direction), .port_b_direction(port_b_direction),
    .port_c_direction(port_c_direction), .halted(halted), .osc_run(osc_run));

  exec_file_model i_exec_file_model (
    .pclk(pclk), .presetn(presetn), .file_we(file_we), .file_addr(file_addr),
    .file_wdata(file_wdata), .wb_count_ff(wb_count_ff), .wb_addr_ff(wb_addr_ff),
    .wb_data_ff(wb_data_ff));

  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one transfer; holds the request until ready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      mismatches++;
      report_and_stop();
    end else begin
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 11; i++) begin
      r = rows[i];
      wb0 = wb_count_ff;
      apb(1'b1, `ADDR_ACC, {24'h0, r.acc});
      apb(1'b1, `ADDR_FILE_VAL, {24'h0, r.fval});
      apb(1'b1, `ADDR_STATUS, {24'h0, r.sts});
      apb(1'b1, `ADDR_INSTR, {16'h0, r.opnd, 4'h0, r.dest, r.op});
      apb(1'b0, `ADDR_ACC, 32'h0);
      chk(rd, {24'h0, r.e_acc});
      apb(1'b0, `ADDR_FILE_VAL, 32'h0);
      chk(rd, {24'h0, r.e_fval});
      apb(1'b0, `ADDR_STATUS, 32'h0);
      chk(rd, {24'h0, r.e_sts});
      if (r.dest && r.op inside {`OP_REG_SUB, `OP_REG_SUBB, `OP_NIB_SWAP, `OP_REG_XOR}) begin
        chk({24'h0, wb_count_ff - wb0}, 32'h1);
        chk({17'h0, wb_addr_ff, wb_data_ff}, {17'h0, r.opnd[6:0], r.e_fval});
        apb(1'b0, `ADDR_FILE_RES, 32'h0);
        chk(rd, {17'h0, r.opnd[6:0], r.e_fval});
      end else begin
        chk({24'h0, wb_count_ff - wb0}, 32'h0);
      end
    end
    $display("test table done");
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    chk({30'h0, osc_run, halted}, 32'h2);
    presetn <= 1'b1;
    apb(1'b0, `ADDR_STATUS, 32'h0);
    chk(rd, 32'h18);
    apb(1'b0, `ADDR_DIR, 32'h0);
    chk(rd, 32'h00ff_ffff);
    $display("test reset done");
    dir_exp = 24'hff_ffff;
    for (int s = 4; s < 8; s++) begin
      apb(1'b1, `ADDR_ACC, 32'h40 + 32'(s));
      apb(1'b1, `ADDR_INSTR, {16'h0, 8'(s), 4'h0, 1'b0, `OP_DIR_LOAD});
      if (s > 4) dir_exp[(s - 5) * 8 +: 8] = 8'(8'h40 + s);
      apb(1'b0, `ADDR_DIR, 32'h0);
      chk(rd, {8'h0, dir_exp});
      chk({8'h0, port_c_direction, port_b_direction, port_a_direction}, {8'h0, dir_exp});
      apb(1'b0, `ADDR_STATUS, 32'h0);
      chk(rd, 32'h18);
    end
    apb(1'b0, `ADDR_INSTR, 32'h0);
    chk(rd, {16'h0, 8'h07, 4'h0, 1'b0, `OP_DIR_LOAD});
    $display("test direction load done");
    apb(1'b0, 8'h20, 32'h0);
    chk({er, rd[30:0]}, 32'h8000_0000);
    apb(1'b1, 8'h3c, 32'h1);
    chk({31'h0, er}, 32'h1);
    $display("test unmapped done");
    apb(1'b1, `ADDR_STATUS, 32'h08);
    apb(1'b0, `ADDR_WDOG, 32'h0);
    chk({31'h0, rd[7:0] != 8'h00}, 32'h1);
    apb(1'b1, `ADDR_INSTR, {28'h0, 1'b0, `OP_SLEEP});
    apb(1'b0, `ADDR_STATUS, 32'h0);
    chk(rd, 32'h10);
    apb(1'b0, `ADDR_WDOG, 32'h0);
    chk(rd, 32'h0001_0000);
    chk({30'h0, osc_run, halted}, 32'h1);
    apb(1'b1, `ADDR_INSTR, {16'h0, 8'hff, 4'h0, 1'b0, `OP_LIT_XOR});
    apb(1'b0, `ADDR_ACC, 32'h0);
    chk(rd, 32'h47);
    apb(1'b1, `ADDR_WAKE, 32'h1);
    apb(1'b0, `ADDR_WDOG, 32'h0);
    chk({29'h0, rd[16], osc_run, halted}, 32'h2);
    $display("test sleep done");
    report_and_stop();
  end
endmodule
